/* File: core/pdlp_consts.svh */
/*
 * constants of the parallel debug link port: register addresses,
 * control word fields, port c bit positions and bus cycle timing.
 * assumes inclusion by bare name from core/ files.
 */
`ifndef PDLP_CONSTS_SVH
`define PDLP_CONSTS_SVH

// ****************************************
// register addresses and indices
// ****************************************
`define PDLP_OUT_PORT_ADDR      8'h70
`define PDLP_IN_PORT_ADDR       8'h72
`define PDLP_HS_PORT_ADDR       8'h74
`define PDLP_CTRL_ADDR          8'h76
`define PDLP_OUT_PORT_IDX       2'h0
`define PDLP_IN_PORT_IDX        2'h1
`define PDLP_HS_PORT_IDX        2'h2
`define PDLP_CTRL_IDX           2'h3

// ****************************************
// control word fields
// ****************************************
`define PDLP_CW_MODE_BIT        7
`define PDLP_CW_A_MODE_HI       6
`define PDLP_CW_A_MODE_LO       5
`define PDLP_CW_A_DIR_BIT       4
`define PDLP_CW_B_MODE_BIT      2
`define PDLP_CW_B_DIR_BIT       1
`define PDLP_CW_SEL_HI          3
`define PDLP_CW_SEL_LO          1
`define PDLP_CW_VAL_BIT         0
`define PDLP_CW_RESET           8'h00
`define PDLP_A_MODE_STROBED     2'h1
`define PDLP_DATA_RESET         8'h00
`define PDLP_BUS_IDLE           8'hFF

// ****************************************
// handshake port bit positions
// ****************************************
`define PDLP_HS_RX_FLAG         0
`define PDLP_HS_IBF             1
`define PDLP_HS_RX_ENABLE       2
`define PDLP_HS_TX_FLAG         3
`define PDLP_HS_BOOT            4
`define PDLP_HS_NMI             5
`define PDLP_HS_TX_ENABLE       6
`define PDLP_HS_OBF_N           7

// ****************************************
// bus cycle timing
// ****************************************
`define PDLP_CLK_PERIOD_NS      25
`define PDLP_T_PULSE_NS         300
`define PDLP_T_HOLD_NS          20
`define PDLP_T_RECOVER_NS       850
`define PDLP_PULSE_CYC  ((`PDLP_T_PULSE_NS + `PDLP_CLK_PERIOD_NS - 1) / `PDLP_CLK_PERIOD_NS)
`define PDLP_HOLD_CYC   ((`PDLP_T_HOLD_NS + `PDLP_CLK_PERIOD_NS - 1) / `PDLP_CLK_PERIOD_NS)
`define PDLP_RECOV_CYC  ((`PDLP_T_RECOVER_NS + `PDLP_CLK_PERIOD_NS - 1) / `PDLP_CLK_PERIOD_NS)

// ****************************************
// controller command port
// ****************************************
`define PDLP_CMD_ADDR           2'h0
`define PDLP_STAT_ADDR          2'h1
`define PDLP_CMD_READ_BIT       10
`define PDLP_CMD_SEL_HI         9
`define PDLP_CMD_SEL_LO         8
`define PDLP_STAT_BUSY_BIT      0
`define PDLP_STAT_RX_BIT        1
`define PDLP_STAT_TX_BIT        2

`endif

/* File: core/pdlp_pkg.sv */
/*
 * types of the parallel debug link port.
 * assumes pdlp_consts.svh for all numeric values except the bus state codes given here.
 */
package pdlp_pkg;

    typedef logic [7:0] pdlp_byte_t;
    typedef logic [1:0] pdlp_sel_t;
    typedef logic [15:0] pdlp_word_t;

    typedef enum logic [2:0]
    {
        PDLP_ST_IDLE    = 3'b000,
        PDLP_ST_SETUP   = 3'b001,
        PDLP_ST_STROBE  = 3'b010,
        PDLP_ST_HOLD    = 3'b011,
        PDLP_ST_RECOVER = 3'b100
    } pdlp_bus_state_t;

endpackage

/* File: core/pdlp_bus_if.sv */
/*
 * processor bus between the controller and the port core.
 * assumes each end raises its output enable only while it drives data.
 */
interface pdlp_bus_if;
    import pdlp_pkg::*;

    logic       host_select_n;
    logic       host_read_strobe_n;
    logic       host_write_strobe_n;
    pdlp_sel_t  host_register_select;
    pdlp_byte_t ctrl_data;
    logic       ctrl_data_oe;
    pdlp_byte_t port_data;
    logic       port_data_oe;
    pdlp_byte_t host_data_bus;
    logic       receive_irq;
    logic       transmit_ready_irq;

    // ****************************************
    // shared data bus level
    // ****************************************
    assign host_data_bus = port_data_oe ? port_data :
                           ctrl_data_oe ? ctrl_data : 8'hFF;

    modport port_end
    (
        input  host_select_n, host_read_strobe_n, host_write_strobe_n,
        input  host_register_select, host_data_bus,
        output port_data, port_data_oe, receive_irq, transmit_ready_irq
    );

    modport ctrl_end
    (
        output host_select_n, host_read_strobe_n, host_write_strobe_n,
        output host_register_select, ctrl_data, ctrl_data_oe,
        input  host_data_bus, receive_irq, transmit_ready_irq
    );

endinterface

/* File: core/pdlp_port_core.sv */
/*
 * port core: four byte registers behind the processor bus, a strobed
 * output port and a strobed input port toward the peer, two interrupts.
 * assumes bus and peer pins synchronous to clk_sys_i.
 */
`include "pdlp_consts.svh"

// Operation
// - drive addressed byte while select, read low
// - processor writes with select and write low
// - no access without select; bus undriven
// - reset clears control word, ports input
// - four addresses; control unreadable; idle floats
// - receive interrupt high when byte waits
// - transmit interrupt high when output empty
// - active-low nmi and boot reset outputs
// - boot reset low active, switch disables
// - a strobed output, b strobed input
// - write lowers full; acknowledge raises, interrupts
// - strobe latches byte; read clears interrupt
// - transmit flag clears at write fall
// - receive flag clears at read fall
// - software writes a6h to control first
// - software writes 05h enabling receive interrupt
// - software writes 0dh enabling transmit interrupt
// - poll handshake bit 3 before sending
// - poll handshake bit 0 before reading
// - boot: 09h, wait 50 ms, 08h
// - nmi: write 0bh then 0ah
module pdlp_port_core
(
    // clock, reset, enable
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire logic               ce_i,
    // processor bus
    pdlp_bus_if.port_end            bus,
    // peer output port
    output      pdlp_pkg::pdlp_byte_t out_data_o,
    output      logic               out_data_oe_o,
    output      logic               output_buffer_full_n_o,
    input  wire logic               peer_acknowledge_n_i,
    // peer input port
    input  wire pdlp_pkg::pdlp_byte_t in_data_i,
    input  wire logic               peer_strobe_n_i,
    output      logic               input_buffer_full_o,
    // peer control lines
    input  wire logic               boot_disable_i,
    output      logic               boot_reset_out_n_o,
    output      logic               nmi_out_n_o
);
    import pdlp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    pdlp_byte_t mode_ff;
    pdlp_byte_t out_port_ff;
    pdlp_byte_t in_port_ff;
    pdlp_byte_t rd_data_ff;
    logic       obf_n_ff;
    logic       ibf_ff;
    logic       tx_flag_ff;
    logic       rx_flag_ff;
    logic       tx_enable_ff;
    logic       rx_enable_ff;
    logic       boot_ff;
    logic       nmi_ff;
    logic       rd_n_prev_ff;
    logic       wr_n_prev_ff;
    logic       ack_n_prev_ff;
    logic       stb_n_prev_ff;
    logic       rd_oe_ff;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic is_idx(input pdlp_sel_t sel, input pdlp_sel_t idx);
        is_idx = (sel == idx);
    endfunction

    wire       selected   = ~bus.host_select_n;
    wire       rd_fall    = selected & rd_n_prev_ff & ~bus.host_read_strobe_n;
    wire       rd_rise    = selected & ~rd_n_prev_ff & bus.host_read_strobe_n;
    wire       wr_fall    = selected & wr_n_prev_ff & ~bus.host_write_strobe_n;
    wire       wr_rise    = selected & ~wr_n_prev_ff & bus.host_write_strobe_n;
    wire       sel_out    = is_idx(bus.host_register_select, `PDLP_OUT_PORT_IDX);
    wire       sel_in     = is_idx(bus.host_register_select, `PDLP_IN_PORT_IDX);
    wire       sel_hs     = is_idx(bus.host_register_select, `PDLP_HS_PORT_IDX);
    wire       sel_ctrl   = is_idx(bus.host_register_select, `PDLP_CTRL_IDX);
    wire [7:0] wdata      = bus.host_data_bus;

    // mode word fields
    wire mode_loaded = mode_ff[`PDLP_CW_MODE_BIT];
    wire a_output    = mode_loaded & ~mode_ff[`PDLP_CW_A_DIR_BIT];
    wire a_strobed   = a_output
                     & (mode_ff[`PDLP_CW_A_MODE_HI:`PDLP_CW_A_MODE_LO]
                        == `PDLP_A_MODE_STROBED);
    wire b_strobed   = mode_loaded & mode_ff[`PDLP_CW_B_MODE_BIT]
                     & mode_ff[`PDLP_CW_B_DIR_BIT];

    // write events
    wire mode_write  = wr_rise & sel_ctrl & wdata[`PDLP_CW_MODE_BIT];
    wire bit_write   = wr_rise & sel_ctrl & ~wdata[`PDLP_CW_MODE_BIT];
    wire [2:0] bit_sel = wdata[`PDLP_CW_SEL_HI:`PDLP_CW_SEL_LO];
    wire bit_val     = wdata[`PDLP_CW_VAL_BIT];
    wire hs_write    = wr_rise & sel_hs;
    wire out_write   = wr_rise & sel_out & a_output;

    // handshake events
    wire ack_fall    = a_strobed & ack_n_prev_ff & ~peer_acknowledge_n_i;
    wire stb_fall    = b_strobed & stb_n_prev_ff & ~peer_strobe_n_i;
    wire tx_clear    = a_strobed & wr_fall & sel_out;
    wire rx_clear    = b_strobed & rd_fall & sel_in;

    // handshake port image
    wire tx_irq_flag = tx_flag_ff & tx_enable_ff;
    wire rx_irq_flag = rx_flag_ff & rx_enable_ff;
    wire [7:0] hs_image =
    {
        obf_n_ff, tx_enable_ff, nmi_ff, boot_ff,
        tx_irq_flag, rx_enable_ff, ibf_ff, rx_irq_flag
    };

    // read selection
    wire       rd_legal = selected & ~bus.host_read_strobe_n
                        & bus.host_write_strobe_n & ~sel_ctrl;
    wire [7:0] rd_mux   = sel_out ? out_port_ff :
                          sel_in  ? (b_strobed ? in_port_ff : in_data_i) :
                          hs_image;

    // next values
    wire nxt_obf_n   = (mode_write | ack_fall) ? 1'b1 :
                       out_write ? ~a_strobed : obf_n_ff;
    wire nxt_tx_flag = mode_write | ack_fall ? 1'b1 :
                       tx_clear ? 1'b0 : tx_flag_ff;
    wire nxt_ibf     = mode_write ? 1'b0 :
                       stb_fall ? 1'b1 :
                       (rd_rise & sel_in) ? 1'b0 : ibf_ff;
    wire nxt_rx_flag = mode_write ? 1'b0 :
                       stb_fall ? 1'b1 :
                       rx_clear ? 1'b0 : rx_flag_ff;

    // ****************************************
    // edge history
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_n_prev_ff  <= 1'b1;
            wr_n_prev_ff  <= 1'b1;
            ack_n_prev_ff <= 1'b1;
            stb_n_prev_ff <= 1'b1;
        end
        else if (ce_i)
        begin
            rd_n_prev_ff  <= bus.host_read_strobe_n;
            wr_n_prev_ff  <= bus.host_write_strobe_n;
            ack_n_prev_ff <= peer_acknowledge_n_i;
            stb_n_prev_ff <= peer_strobe_n_i;
        end
    end

    // ****************************************
    // mode word and single-bit commands
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mode_ff      <= `PDLP_CW_RESET;
            tx_enable_ff <= 1'b0;
            rx_enable_ff <= 1'b0;
            boot_ff      <= 1'b0;
            nmi_ff       <= 1'b0;
        end
        else if (ce_i)
        begin
            if (mode_write)
            begin
                mode_ff      <= wdata;
                tx_enable_ff <= 1'b0;
                rx_enable_ff <= 1'b0;
                boot_ff      <= 1'b0;
                nmi_ff       <= 1'b0;
            end
            else if (bit_write)
            begin
                if (bit_sel == 3'(`PDLP_HS_RX_ENABLE))
                    rx_enable_ff <= bit_val;
                if (bit_sel == 3'(`PDLP_HS_TX_ENABLE))
                    tx_enable_ff <= bit_val;
                if (bit_sel == 3'(`PDLP_HS_BOOT))
                    boot_ff <= bit_val;
                if (bit_sel == 3'(`PDLP_HS_NMI))
                    nmi_ff <= bit_val;
            end
            else if (hs_write & mode_loaded)
            begin
                boot_ff <= wdata[`PDLP_HS_BOOT];
                nmi_ff  <= wdata[`PDLP_HS_NMI];
            end
        end
    end

    // ****************************************
    // data ports and handshake flags
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            out_port_ff <= `PDLP_DATA_RESET;
            in_port_ff  <= `PDLP_DATA_RESET;
            obf_n_ff    <= 1'b1;
            ibf_ff      <= 1'b0;
            tx_flag_ff  <= 1'b0;
            rx_flag_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            if (out_write)
                out_port_ff <= wdata;
            if (stb_fall)
                in_port_ff <= in_data_i;
            obf_n_ff   <= nxt_obf_n;
            ibf_ff     <= nxt_ibf;
            tx_flag_ff <= nxt_tx_flag;
            rx_flag_ff <= nxt_rx_flag;
        end
    end

    // ****************************************
    // read data register
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_data_ff <= `PDLP_DATA_RESET;
            rd_oe_ff   <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_data_ff <= rd_mux;
            rd_oe_ff   <= rd_legal;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign bus.port_data            = rd_data_ff;
    assign bus.port_data_oe         = rd_oe_ff & rd_legal;
    assign bus.receive_irq          = rx_irq_flag;
    assign bus.transmit_ready_irq   = tx_irq_flag;
    assign out_data_o               = out_port_ff;
    assign out_data_oe_o            = a_output;
    assign output_buffer_full_n_o   = obf_n_ff;
    assign input_buffer_full_o      = ibf_ff;
    assign boot_reset_out_n_o       = ~(boot_ff & ~boot_disable_i);
    assign nmi_out_n_o              = ~nmi_ff;

endmodule // pdlp_port_core

/* File: core/pdlp_host_ctrl.sv */
/*
 * bus controller: takes commands on a plain register port and runs
 * timed read and write cycles on the processor bus.
 * assumes a port core on the far side of pdlp_bus_if.
 */
`include "pdlp_consts.svh"

module pdlp_host_ctrl
(
    // clock, reset, enable
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire logic               ce_i,
    // command port
    input  wire pdlp_pkg::pdlp_sel_t  addr_i,
    input  wire pdlp_pkg::pdlp_word_t wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output      pdlp_pkg::pdlp_word_t rdata_o,
    // processor bus
    pdlp_bus_if.ctrl_end            bus
);
    import pdlp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    pdlp_bus_state_t state_ff;
    pdlp_bus_state_t nxt_state;
    logic [5:0]      cnt_ff;
    logic [5:0]      nxt_cnt;
    logic            is_read_ff;
    pdlp_sel_t       sel_ff;
    pdlp_byte_t      data_ff;
    pdlp_byte_t      rd_byte_ff;
    pdlp_word_t      rdata_ff;

    localparam logic [5:0] PULSE_CYC = 6'(`PDLP_PULSE_CYC);
    localparam logic [5:0] HOLD_CYC  = 6'(`PDLP_HOLD_CYC);
    localparam logic [5:0] RECOV_CYC = 6'(`PDLP_RECOV_CYC);

    wire busy     = (state_ff != PDLP_ST_IDLE);
    wire start    = wr_i & (addr_i == `PDLP_CMD_ADDR) & ~busy;
    wire last_cyc = (cnt_ff == 6'h01);
    wire [15:0] status =
    {
        rd_byte_ff, 5'h00, bus.transmit_ready_irq, bus.receive_irq, busy
    };
    wire [15:0] rd_mux = (addr_i == `PDLP_STAT_ADDR) ? status : 16'h0000;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = last_cyc ? cnt_ff : cnt_ff - 6'h01;
        unique case (state_ff)
            PDLP_ST_IDLE:
                if (start)
                begin
                    nxt_state = PDLP_ST_SETUP;
                    nxt_cnt   = 6'h01;
                end
            PDLP_ST_SETUP:
            begin
                nxt_state = PDLP_ST_STROBE;
                nxt_cnt   = PULSE_CYC;
            end
            PDLP_ST_STROBE:
                if (last_cyc)
                begin
                    nxt_state = PDLP_ST_HOLD;
                    nxt_cnt   = HOLD_CYC;
                end
            PDLP_ST_HOLD:
                if (last_cyc)
                begin
                    nxt_state = PDLP_ST_RECOVER;
                    nxt_cnt   = RECOV_CYC;
                end
            PDLP_ST_RECOVER:
                if (last_cyc)
                    nxt_state = PDLP_ST_IDLE;
            default:
                nxt_state = PDLP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_ff   <= PDLP_ST_IDLE;
            cnt_ff     <= 6'h01;
            is_read_ff <= 1'b0;
            sel_ff     <= 2'h0;
            data_ff    <= 8'h00;
            rd_byte_ff <= 8'h00;
            rdata_ff   <= 16'h0000;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            rdata_ff <= rd_i ? rd_mux : 16'h0000;
            if (start)
            begin
                is_read_ff <= wdata_i[`PDLP_CMD_READ_BIT];
                sel_ff     <= wdata_i[`PDLP_CMD_SEL_HI:`PDLP_CMD_SEL_LO];
                data_ff    <= wdata_i[7:0];
            end
            if ((state_ff == PDLP_ST_STROBE) & last_cyc & is_read_ff)
                rd_byte_ff <= bus.host_data_bus;
        end
    end

    // ****************************************
    // bus pins
    // ****************************************
    wire in_cycle = (state_ff == PDLP_ST_SETUP) | (state_ff == PDLP_ST_STROBE)
                  | (state_ff == PDLP_ST_HOLD);
    wire strobing = (state_ff == PDLP_ST_STROBE);

    assign bus.host_select_n        = ~in_cycle;
    assign bus.host_read_strobe_n   = ~(strobing & is_read_ff);
    assign bus.host_write_strobe_n  = ~(strobing & ~is_read_ff);
    assign bus.host_register_select = sel_ff;
    assign bus.ctrl_data            = data_ff;
    assign bus.ctrl_data_oe         = in_cycle & ~is_read_ff;
    assign rdata_o                  = rdata_ff;

endmodule // pdlp_host_ctrl

/* File: test/pdlp_link_checker.sv */
/* bus checker of the parallel debug link port.
   assumes instantiation beside pdlp_bus_if, signals by name. */
module pdlp_link_checker
    import pdlp_pkg::*;
(
    // clock and reset
    input wire logic      clk_sys_i,
    input wire logic      reset_i,
    // processor bus
    input wire logic      host_select_n,
    input wire logic      host_read_strobe_n,
    input wire logic      host_write_strobe_n,
    input wire pdlp_sel_t host_register_select,
    input wire logic      ctrl_data_oe,
    input wire logic      port_data_oe,
    input wire logic      receive_irq,
    input wire logic      transmit_ready_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // bus properties
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    property p_unselected_float;
        host_select_n |-> !port_data_oe;
    endproperty
    a_unselected_float: assert property (p_unselected_float) else $error("drive unselected");
    property p_control_unread;
        host_register_select == 2'h3 |-> !port_data_oe;
    endproperty
    a_control_unread: assert property (p_control_unread) else $error("control driven");
    property p_idle_float;
        host_read_strobe_n && host_write_strobe_n |-> !port_data_oe;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("drive while idle");
    property p_read_drive;
        $fell(host_read_strobe_n) && !host_select_n && host_register_select != 2'h3
            |=> port_data_oe [*8];
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
    property p_no_contention;
        port_data_oe |-> !ctrl_data_oe && host_write_strobe_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention");
    property p_tx_clear;
        $fell(host_write_strobe_n) && !host_select_n && host_register_select == 2'h0
            |=> !transmit_ready_irq;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx flag kept");
    property p_rx_clear;
        $fell(host_read_strobe_n) && !host_select_n && host_register_select == 2'h1
            |=> !receive_irq;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx flag kept");
    property p_reset_quiet;
        $fell(reset_i) |-> !receive_irq && !transmit_ready_irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("irq after reset");
endmodule // pdlp_link_checker

/* File: test/parallel_debug_link_port_bench.sv */
/* bench of the parallel debug link port: controller and port core joined.
   assumes the 48 cycle bus cycle of the controller. */
module parallel_debug_link_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pdlp_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0;
    logic ack_n = 1'b1, stb_n = 1'b1, boot_dis = 1'b0;
    logic obf_n, ibf, boot_n, nmi_n, a_oe;
    pdlp_sel_t  addr = 2'h0;
    pdlp_word_t wdata = 16'h0000, rdata, s;
    pdlp_byte_t in_data = 8'h3C, out_data, b;
    int err_count = 0, comparisons = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    pdlp_bus_if pdlp_bus_if_inst ();
    pdlp_host_ctrl pdlp_host_ctrl_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .bus(pdlp_bus_if_inst.ctrl_end));
    pdlp_port_core pdlp_port_core_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .bus(pdlp_bus_if_inst.port_end), .out_data_o(out_data), .out_data_oe_o(a_oe),
        .output_buffer_full_n_o(obf_n), .peer_acknowledge_n_i(ack_n), .in_data_i(in_data),
        .peer_strobe_n_i(stb_n), .input_buffer_full_o(ibf), .boot_disable_i(boot_dis),
        .boot_reset_out_n_o(boot_n), .nmi_out_n_o(nmi_n));
    pdlp_link_checker pdlp_link_checker_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .host_select_n(pdlp_bus_if_inst.host_select_n),
        .host_read_strobe_n(pdlp_bus_if_inst.host_read_strobe_n),
        .host_write_strobe_n(pdlp_bus_if_inst.host_write_strobe_n),
        .host_register_select(pdlp_bus_if_inst.host_register_select),
        .ctrl_data_oe(pdlp_bus_if_inst.ctrl_data_oe),
        .port_data_oe(pdlp_bus_if_inst.port_data_oe),
        .receive_irq(pdlp_bus_if_inst.receive_irq),
        .transmit_ready_irq(pdlp_bus_if_inst.transmit_ready_irq));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic dev(input pdlp_sel_t idx, input logic r, input pdlp_byte_t d);
        @(posedge clk_sys_i);
        addr <= 2'h0;
        wdata <= {5'h00, r, idx, d};
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        repeat (50) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic dev_rd(input pdlp_sel_t idx, output pdlp_byte_t d);
        dev(idx, 1'b1, 8'h00);
        @(posedge clk_sys_i);
        addr <= 2'h1;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        d = rdata[15:8];
        s = rdata;
    endtask
    task automatic peer_pulse(input logic is_ack);
        @(posedge clk_sys_i);
        if (is_ack)
            ack_n <= 1'b0;
        else
            stb_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        ack_n <= 1'b1;
        stb_n <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        check("peer lines", 5'b01011, {a_oe, obf_n, ibf, boot_n, nmi_n});
        dev_rd(2'h3, b);
        check("control read", 8'hFF, b);
    endtask
    task automatic t_init;
        dev(2'h3, 1'b0, 8'hA6);
        check("a output", 1'b1, a_oe);
        dev(2'h3, 1'b0, 8'h05);
        dev(2'h3, 1'b0, 8'h0D);
        check("tx irq idle", 1'b1, pdlp_bus_if_inst.transmit_ready_irq);
        dev_rd(2'h2, b);
        check("handshake idle", 8'hCC, b);
    endtask
    task automatic t_send;
        dev(2'h0, 1'b0, 8'h5A);
        check("out byte", 8'h5A, out_data);
        check("obf after write", 2'b00, {obf_n, pdlp_bus_if_inst.transmit_ready_irq});
        peer_pulse(1'b1);
        check("obf after ack", 2'b11, {obf_n, pdlp_bus_if_inst.transmit_ready_irq});
    endtask
    task automatic t_recv;
        peer_pulse(1'b0);
        check("ibf and irq", 2'b11, {ibf, pdlp_bus_if_inst.receive_irq});
        dev_rd(2'h2, b);
        check("handshake full", 8'hCF, b);
        check("status irqs", 3'b110, s[2:0]);
        dev_rd(2'h1, b);
        check("in byte", 8'h3C, b);
        check("ibf after read", 2'b00, {ibf, pdlp_bus_if_inst.receive_irq});
    endtask
    task automatic t_bits;
        dev(2'h3, 1'b0, 8'h09);
        check("boot on", 1'b0, boot_n);
        @(posedge clk_sys_i);
        boot_dis <= 1'b1;
        #1;
        check("boot switch", 1'b1, boot_n);
        @(posedge clk_sys_i);
        boot_dis <= 1'b0;
        dev(2'h3, 1'b0, 8'h08);
        dev(2'h3, 1'b0, 8'h0B);
        check("nmi on", 2'b10, {boot_n, nmi_n});
        dev(2'h3, 1'b0, 8'h0A);
        check("nmi off", 2'b11, {boot_n, nmi_n});
        dev(2'h2, 1'b0, 8'h30);
        check("handshake write", 2'b00, {boot_n, nmi_n});
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_init();
        t_send();
        t_recv();
        t_bits();
        tally_and_finish();
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys_i);
        err_count++;
        tally_and_finish();
    end
endmodule // parallel_debug_link_port_bench
